/* thermal_trip_params.svh */
// Purpose: Timing counts and reset values for the thermal trip latch
// Assumes: Included by bare name from the design files
// Notes: Every figure sits here once as a define
`ifndef THERMAL_TRIP_PARAMS_SVH
`define THERMAL_TRIP_PARAMS_SVH

// Nominal trip level of the on-die comparator, in degrees Celsius
`define TRIP_LEVEL_C 135

// Clock rate of sys_clk, in Hz
`define CLK_FREQ_HZ 100_000_000

// Longest time allowed for each rail to fall to half nominal, seconds
`define RAIL_OFF_TIME_S 5

// Rail fall window as clock cycles (longest time, rounded down)
`define RAIL_OFF_CYCLES (`RAIL_OFF_TIME_S * `CLK_FREQ_HZ)

// Width of the rail fall timer and of the trip counter
`define RAIL_TMR_W 32
`define TRIP_CNT_W 8

// Reset values of the timer and the counter, then the counter step and ceiling
`define RAIL_TMR_RST 32'h0000_0000
`define TRIP_CNT_RST 8'h00
`define TRIP_CNT_ONE 8'h01
`define TRIP_CNT_MAX 8'hFF

`endif

/* thermal_trip_pkg.sv */
// Purpose: Types shared by the thermal trip latch
// Assumes: Nothing beyond the params header
// Notes: State codes are left to the tools
package thermal_trip_pkg;

  // Protection state of the trip latch
  typedef enum logic [1:0] {
    ST_RUN,
    ST_TRIPPED,
    ST_RAILS_OFF
  } trip_state_t;

endpackage

/* level_sync.sv */
// Purpose: Two-stage synchroniser for one level
// Assumes: Async active-low reset, already released in step with clk
// Notes: The first stage feeds only the second stage
module level_sync
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic level_in,
  output logic level_out
);

  logic meta_r;
  logic meta_nxt;
  logic stable_r;
  logic stable_nxt;

  // Next values of both stages
  always_comb
  begin
    meta_nxt = level_in;
    stable_nxt = meta_r;
  end

  // Stage registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= 1'b0;
      stable_r <= 1'b0;
    end
    else
    begin
      meta_r <= meta_nxt;
      stable_r <= stable_nxt;
    end
  end

  assign level_out = stable_r;

endmodule // level_sync

/* thermal_trip_shutdown_latch.sv */
// Purpose: Over-temperature trip latch that halts the core
// Assumes: temp_over is the raw comparator flag, high above the trip level
// Assumes: cpu_reset_n is the processor system reset, sync to sys_clk
// Assumes: vcc_good and vtt_good are high while each rail is above half
// Notes: arst_n is power-on reset; release is synchronised here
// Notes: Power loss is seen through the two rail-good levels
`include "thermal_trip_params.svh"
module thermal_trip_shutdown_latch
  import thermal_trip_pkg::*;
#(
  parameter logic [`RAIL_TMR_W-1:0] RAIL_OFF_CYCLES =
    `RAIL_TMR_W'(`RAIL_OFF_CYCLES)
)
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic temp_over,
  input wire logic cpu_reset_n,
  input wire logic vcc_good,
  input wire logic vtt_good,
  output logic over_temp_halt_n,
  output logic exec_halt,
  output logic rail_timeout,
  output logic [`TRIP_CNT_W-1:0] trip_count
);

  // Reset release synchroniser
  logic [1:0] rst_sync_r;
  logic rst_n;

  // Synchronised comparator flag
  logic temp_hot;

  // Protection state
  trip_state_t state_r;
  trip_state_t state_nxt;

  // Registered outputs
  logic halt_n_r;
  logic halt_n_nxt;
  logic exec_halt_r;
  logic exec_halt_nxt;
  logic rail_timeout_r;
  logic rail_timeout_nxt;

  // Rail fall timer and trip counter
  logic [`RAIL_TMR_W-1:0] rail_tmr_r;
  logic [`RAIL_TMR_W-1:0] rail_tmr_nxt;
  logic [`TRIP_CNT_W-1:0] trip_cnt_r;
  logic [`TRIP_CNT_W-1:0] trip_cnt_nxt;

  // Decoded conditions
  logic rails_up;
  logic rails_down;
  logic in_reset;
  logic trip_event;

  // Asynchronous assert, synchronous release of the reset
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_sync_r <= 2'h0;
    end
    else
    begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // Comparator flag brought into the clock domain
  level_sync u_temp_sync
  (
    .clk(sys_clk),
    .rst_n(rst_n),
    .level_in(temp_over),
    .level_out(temp_hot)
  );

  // Decoded supply and reset conditions
  assign rails_up = vcc_good && vtt_good;
  assign rails_down = !vcc_good && !vtt_good;
  assign in_reset = !cpu_reset_n;

  // Trip only counts while both rails are valid
  assign trip_event = (state_r == ST_RUN) && temp_hot && rails_up;

  // Protection state machine
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:
      begin
        if (trip_event)
        begin
          state_nxt = ST_TRIPPED;
        end
      end
      ST_TRIPPED:
      begin
        if (rails_down)
        begin
          state_nxt = ST_RAILS_OFF;
        end
        else if (in_reset && !temp_hot)
        begin
          state_nxt = ST_RUN;
        end
        else
        begin
          state_nxt = ST_TRIPPED;
        end
      end
      ST_RAILS_OFF:
      begin
        // Restart only on a reset with a cool die, never on power alone
        if (in_reset && !temp_hot)
        begin
          state_nxt = ST_RUN;
        end
      end
      default:
      begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // Output levels follow the next state so they change with it
  always_comb
  begin
    halt_n_nxt = 1'b1;
    exec_halt_nxt = 1'b0;
    case (state_nxt)
      ST_RUN:
      begin
        halt_n_nxt = 1'b1;
        exec_halt_nxt = 1'b0;
      end
      ST_TRIPPED:
      begin
        halt_n_nxt = 1'b0;
        exec_halt_nxt = 1'b1;
      end
      ST_RAILS_OFF:
      begin
        halt_n_nxt = 1'b1;
        exec_halt_nxt = 1'b1;
      end
      default:
      begin
        halt_n_nxt = 1'b1;
        exec_halt_nxt = 1'b0;
      end
    endcase
  end

  // Watch for rails that fail to fall inside the allowed window
  always_comb
  begin
    rail_tmr_nxt = rail_tmr_r;
    rail_timeout_nxt = rail_timeout_r;
    if (state_r != ST_TRIPPED)
    begin
      rail_tmr_nxt = `RAIL_TMR_RST;
      rail_timeout_nxt = 1'b0;
    end
    else if (rail_tmr_r >= RAIL_OFF_CYCLES - `RAIL_TMR_W'(1))
    begin
      rail_timeout_nxt = 1'b1;
    end
    else
    begin
      rail_tmr_nxt = rail_tmr_r + `RAIL_TMR_W'(1);
    end
  end

  // Saturating count of trips since power-on
  always_comb
  begin
    trip_cnt_nxt = trip_cnt_r;
    if (trip_event && (trip_cnt_r != `TRIP_CNT_MAX))
    begin
      trip_cnt_nxt = trip_cnt_r + `TRIP_CNT_ONE;
    end
  end

  // State and output registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_RUN;
      halt_n_r <= 1'b1;
      exec_halt_r <= 1'b0;
      rail_timeout_r <= 1'b0;
      rail_tmr_r <= `RAIL_TMR_RST;
      trip_cnt_r <= `TRIP_CNT_RST;
    end
    else
    begin
      state_r <= state_nxt;
      halt_n_r <= halt_n_nxt;
      exec_halt_r <= exec_halt_nxt;
      rail_timeout_r <= rail_timeout_nxt;
      rail_tmr_r <= rail_tmr_nxt;
      trip_cnt_r <= trip_cnt_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign over_temp_halt_n = halt_n_r;
  assign exec_halt = exec_halt_r;
  assign rail_timeout = rail_timeout_r;
  assign trip_count = trip_cnt_r;

endmodule // thermal_trip_shutdown_latch

/* trip_latch_monitor.sv */
// Purpose: Port checks for the trip latch
// Assumes: temp_over held low around reset release
// Notes: Synced temperature lags temp_over by two edges
module trip_latch_monitor
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic temp_over,
  input wire logic cpu_reset_n,
  input wire logic vcc_good,
  input wire logic vtt_good,
  input wire logic over_temp_halt_n,
  input wire logic exec_halt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  // Trip latched with power left
  sequence latched_s;
    !over_temp_halt_n && (vcc_good || vtt_good);
  endsequence
  // Reset seen with a cool synced die
  sequence cool_s;
    !cpu_reset_n && !$past(temp_over, 2);
  endsequence
  // Rails-off state at the outputs
  sequence off_s;
    over_temp_halt_n && exec_halt;
  endsequence
  a_trip_cause:
    assert property ($fell(over_temp_halt_n) |-> $past(temp_over, 3))
    else $error("trip without hot sample");
  a_trip_taken:
    assert property (over_temp_halt_n && !exec_halt && vcc_good &&
      vtt_good && $past(temp_over, 2) |=> !over_temp_halt_n && exec_halt)
    else $error("hot die not tripped");
  a_latch_hold:
    assert property (latched_s ##0 cpu_reset_n |=> !over_temp_halt_n)
    else $error("trip dropped");
  a_cool_clear:
    assert property (latched_s ##0 cool_s |=> over_temp_halt_n && !exec_halt)
    else $error("cool reset kept trip");
  a_hot_keep:
    assert property (latched_s ##0 (!cpu_reset_n && $past(temp_over, 2))
      |=> !over_temp_halt_n && exec_halt)
    else $error("hot reset cleared trip");
  a_rails_release:
    assert property (!over_temp_halt_n && !vcc_good && !vtt_good |=> off_s)
    else $error("trip kept after rails off");
  a_off_stays:
    assert property (off_s ##0 cpu_reset_n |=> off_s)
    else $error("halt left without reset");
  a_off_exit:
    assert property (off_s ##0 cool_s |=> !exec_halt)
    else $error("halt kept after cool reset");
endmodule // trip_latch_monitor

bind thermal_trip_shutdown_latch trip_latch_monitor mon
(
  .sys_clk, .arst_n, .temp_over, .cpu_reset_n, .vcc_good, .vtt_good,
  .over_temp_halt_n, .exec_halt
);

/* rail_partner.sv */
// Purpose: Power control model for both rails
// Assumes: dly of 1000 or more means rails never fall
// Notes: Rails come back only on restore
module rail_partner
(
  input wire logic sys_clk,
  input wire logic over_temp_halt_n,
  input wire logic [31:0] dly,
  input wire logic restore,
  output logic vcc_good = 1'h1,
  output logic vtt_good = 1'h1
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  // Drop core then termination rail after trip
  always @(negedge sys_clk)
  begin
    n = over_temp_halt_n ? 0 : n + 1;
    if (dly < 1000 && n > dly) vcc_good <= 1'h0;
    if (dly < 1000 && n > dly + 1) vtt_good <= 1'h0;
    if (restore) vcc_good <= 1'h1;
    if (restore) vtt_good <= 1'h1;
  end
endmodule // rail_partner

/* thermal_trip_shutdown_latch_bench.sv */
// Purpose: Self-checking bench for the trip latch
// Assumes: Partner model drives both rail-good levels
// Notes: Rail timeout shortened to 20 cycles
module thermal_trip_shutdown_latch_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TMO = 20;
  logic sys_clk = 1'h0, arst_n = 1'h0, temp_over = 1'h0;
  logic cpu_reset_n = 1'h1, restore = 1'h0;
  logic vcc_good, vtt_good, over_temp_halt_n, exec_halt, rail_timeout;
  logic [7:0] trip_count;
  int dly = 5, error_cnt = 0, tests_run = 0, i, k, hot;
  int st = 0, pst = 0, s1 = 0, s2 = 0, rc = 0, cnt = 0;
  always #5 sys_clk = ~sys_clk;
  thermal_trip_shutdown_latch #(.RAIL_OFF_CYCLES(32'(TMO))) uut
  (
    .sys_clk, .arst_n, .temp_over, .cpu_reset_n, .vcc_good, .vtt_good,
    .over_temp_halt_n, .exec_halt, .rail_timeout, .trip_count
  );
  rail_partner pm
  (
    .sys_clk, .over_temp_halt_n, .dly(32'(dly)), .restore, .vcc_good,
    .vtt_good
  );
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Reference model: 0 run, 1 tripped, 2 rails off
  always @(posedge sys_clk)
  begin
    pst = st;
    if (!arst_n || rc < 2)
    begin
      rc = arst_n ? rc + 1 : 0;
      {st, s1, s2, cnt} = '0;
    end
    else
    begin
      hot = s2;
      s2 = s1;
      s1 = temp_over;
      if (st == 0 && hot && vcc_good && vtt_good) cnt += (cnt < 255);
      if (st == 0 && hot && vcc_good && vtt_good) st = 1;
      else if (st == 1 && !vcc_good && !vtt_good) st = 2;
      else if (st != 0 && !cpu_reset_n && !hot) st = 0;
    end
  end
  // Compare outputs with the model
  always @(negedge sys_clk)
  begin
    chk("halt_n", 8'(st != 1), 8'(over_temp_halt_n));
    chk("exec_halt", 8'(st != 0), 8'(exec_halt));
    chk("trip_count", 8'(cnt), trip_count);
    if (st == 0 && pst == 0) chk("timeout", 8'h00, 8'(rail_timeout));
  end
  // Watchdog
  initial
  begin
    #200000;
    error_cnt++;
    summarize();
  end
  // Main sequence
  initial
  begin
    void'($urandom(72633));
    repeat (2) @(negedge sys_clk);
    arst_n = 1'h1;
    for (i = 0; i < 3000; i++)
    begin
      @(negedge sys_clk);
      if ($urandom % 12 == 0) temp_over = ~temp_over;
      if (i > 1496 && i < 1506) temp_over = 1'h0;
      if (i % 100 == 0) dly = 1 + $urandom % 40;
      cpu_reset_n = ($urandom % 9 != 0);
      restore = ($urandom % 25 == 0);
      arst_n = (i != 1500);
    end
    // One-cycle pulses, each cleared by a cool reset four cycles later, until count saturates
    {temp_over, restore, cpu_reset_n, dly} = {2'h1, 1'h0, 32'd5000};
    repeat (3) @(negedge sys_clk);
    {restore, cpu_reset_n} = 2'h1;
    @(negedge sys_clk);
    cpu_reset_n = 1'h1;
    for (k = 0; k < 260; k++)
    begin
      temp_over = 1'h1;
      @(negedge sys_clk);
      temp_over = 1'h0;
      repeat (3) @(negedge sys_clk);
      cpu_reset_n = 1'h0;
      @(negedge sys_clk);
      cpu_reset_n = 1'h1;
    end
    // Rails hold up: timeout flag, then rails off, then power back
    temp_over = 1'h1;
    repeat (TMO + 10) @(negedge sys_clk);
    chk("timeout", 8'h01, 8'(rail_timeout));
    dly = 2;
    repeat (6) @(negedge sys_clk);
    restore = 1'h1;
    repeat (6) @(negedge sys_clk);
    summarize();
  end
endmodule // thermal_trip_shutdown_latch_bench
